// ### bms_meas.sv
`timescale 1ns/1ps
// Overview of operation
// - Sixteen-bit charge integrator, 250 ms period
// - Continuous mode: result each period, flag, pin
// - Single shot does exactly one integration
// - Charge result is two's complement
// - Source select 1 stores thermistor results
// - Source select 0 stores die temperature
// - New source appears at next temperature tick
// - Each of three slots takes the selected source
// - Cell codes summed, quarter kept as 16-bit stack value
// - All cells refreshed every 250 ms
// - Temperature sampled every 2 seconds
// - Stack sum recomputed every 250 ms
// - Byte pairs read from one sample
// - Converter enable set entering normal mode
// - Writing status bit clears flag, releases pin
module bms_meas #(
   parameter int UPDATE_CYCLES = bms_pkg::UPDATE_CYCLES,
   parameter int TEMP_CYCLES = bms_pkg::TEMP_CYCLES
)
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic ce,
   input wire logic enter_normal,
   input wire logic [bms_pkg::NUM_CELLS*bms_pkg::CELL_W-1:0] cell_code,
   input wire logic [bms_pkg::NUM_TEMPS*bms_pkg::CELL_W-1:0] therm_code,
   input wire logic [bms_pkg::NUM_TEMPS*bms_pkg::CELL_W-1:0] die_code,
   input wire logic signed [bms_pkg::CC_W-1:0] sense_sample,
   input wire logic sense_valid,
   input wire bms_pkg::bms_bus_t bus,
   output logic [7:0] rdata,
   output logic adc_enable,
   output logic host_alert
);
   logic [7:0] ctrl;
   logic done_flag;
   logic [bms_pkg::CELL_W-1:0] cell_reg [bms_pkg::NUM_CELLS];
   logic [bms_pkg::CELL_W-1:0] temp_reg [bms_pkg::NUM_TEMPS];
   logic [bms_pkg::SUM_W-1:0] stack_sum_value;
   logic signed [bms_pkg::CC_W-1:0] acc;
   logic signed [bms_pkg::CC_W-1:0] cc_result;
   logic [7:0] low_shadow;
   logic [7:0] next_rdata;
   wire [bms_pkg::SUM_W+1:0] cell_term [bms_pkg::NUM_CELLS];
   // Two spare bits hold the full sum of all cells before scaling
   logic [bms_pkg::SUM_W+1:0] cell_total;
   wire [bms_pkg::SUM_W-1:0] next_sum = cell_total[bms_pkg::SUM_W+1:2];
   wire [bms_pkg::NUM_CELLS-1:0] cell_hit;
   wire [bms_pkg::NUM_TEMPS-1:0] temp_hit;
   logic [15:0] cell_word;
   logic [15:0] temp_word;
   wire [7:0] off = bus.addr;

   logic continuous_count_enable;
   logic single_count_trigger;
   logic temp_source_select_alt;
   wire cc_run = continuous_count_enable || single_count_trigger;
   wire cell_tick;
   wire temp_tick;
   wire cc_tick;

   bms_timer #(.PERIOD(UPDATE_CYCLES)) u_cell_timer (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .ce(ce),
      .run(adc_enable),
      .tick(cell_tick)
   );
   bms_timer #(.PERIOD(TEMP_CYCLES)) u_temp_timer (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .ce(ce),
      .run(adc_enable),
      .tick(temp_tick)
   );
   bms_timer #(.PERIOD(UPDATE_CYCLES)) u_cc_timer (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .ce(ce),
      .run(cc_run),
      .tick(cc_tick)
   );

   // Scaled once after the sum, so low bits of each cell are not lost
   always_comb
   begin
      cell_total = '0;
      for (int i = 0; i < bms_pkg::NUM_CELLS; i++)
         cell_total = cell_total + cell_term[i];
   end

   genvar g;
   generate
      for (g = 0; g < bms_pkg::NUM_CELLS; g++)
      begin : g_cell
         localparam logic [7:0] CELL_ADDR = 8'(bms_pkg::ADDR_CELL_BASE + 2 * g);
         assign cell_hit[g] = off[7:1] == CELL_ADDR[7:1];
         assign cell_term[g] = (bms_pkg::SUM_W+2)'(cell_code[g*bms_pkg::CELL_W +: bms_pkg::CELL_W]);
         always_ff @(posedge clk_sys or negedge nrst)
         begin
            if (!nrst)
               cell_reg[g] <= '0;
            else if (ce && cell_tick)
               cell_reg[g] <= cell_code[g*bms_pkg::CELL_W +: bms_pkg::CELL_W];
         end
      end
      for (g = 0; g < bms_pkg::NUM_TEMPS; g++)
      begin : g_temp
         localparam logic [7:0] TEMP_ADDR = 8'(bms_pkg::ADDR_TEMP_BASE + 2 * g);
         assign temp_hit[g] = off[7:1] == TEMP_ADDR[7:1];
         // Source change only shows at next interval, hence up to 2 s lag
         wire [bms_pkg::CELL_W-1:0] src = temp_source_select_alt ?
            therm_code[g*bms_pkg::CELL_W +: bms_pkg::CELL_W] :
            die_code[g*bms_pkg::CELL_W +: bms_pkg::CELL_W];
         always_ff @(posedge clk_sys or negedge nrst)
         begin
            if (!nrst)
               temp_reg[g] <= '0;
            else if (ce && temp_tick)
               temp_reg[g] <= src;
         end
      end
   endgenerate

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         stack_sum_value <= '0;
      else if (ce && cell_tick)
         stack_sum_value <= next_sum;
   end

   // Charge integrator, wraps in 16 bits like the counter it models
   wire signed [bms_pkg::CC_W-1:0] cc_add = sense_valid ? sense_sample : '0;
   wire signed [bms_pkg::CC_W-1:0] cc_sum = acc + cc_add;

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         acc <= '0;
      else if (ce)
      begin
         if (!cc_run || cc_tick)
            acc <= '0;
         else
            acc <= cc_sum;
      end
   end

   // Last sample of the period lands in the result, none is lost
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         cc_result <= '0;
      else if (ce && cc_tick)
         cc_result <= cc_sum;
   end

   wire ctrl_wr = bus.wr && bus.addr == bms_pkg::ADDR_CTRL;
   wire stat_wr = bus.wr && bus.addr == bms_pkg::ADDR_STATUS;
   wire shot_done = cc_tick && !continuous_count_enable;
   wire done_clr = stat_wr && bus.wdata[bms_pkg::STAT_DONE_BIT];

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         continuous_count_enable <= bms_pkg::CTRL_RESET[bms_pkg::CTRL_CONT_BIT];
      else if (ce && ctrl_wr)
         continuous_count_enable <= bus.wdata[bms_pkg::CTRL_CONT_BIT];
   end

   // Completion beats a same-cycle write, so a stale request never reruns
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         single_count_trigger <= bms_pkg::CTRL_RESET[bms_pkg::CTRL_SHOT_BIT];
      else if (ce)
      begin
         if (shot_done)
            single_count_trigger <= 1'b0;
         else if (ctrl_wr)
            single_count_trigger <= bus.wdata[bms_pkg::CTRL_SHOT_BIT];
      end
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         temp_source_select_alt <= bms_pkg::CTRL_RESET[bms_pkg::CTRL_TSEL_BIT];
      else if (ce && ctrl_wr)
         temp_source_select_alt <= bus.wdata[bms_pkg::CTRL_TSEL_BIT];
   end

   // Entering normal mode wins over a write that clears the bit
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         adc_enable <= bms_pkg::CTRL_RESET[bms_pkg::CTRL_ADC_BIT];
      else if (ce)
      begin
         if (enter_normal)
            adc_enable <= 1'b1;
         else if (ctrl_wr)
            adc_enable <= bus.wdata[bms_pkg::CTRL_ADC_BIT];
      end
   end

   always_comb
   begin
      ctrl = 8'h00;
      ctrl[bms_pkg::CTRL_CONT_BIT] = continuous_count_enable;
      ctrl[bms_pkg::CTRL_SHOT_BIT] = single_count_trigger;
      ctrl[bms_pkg::CTRL_TSEL_BIT] = temp_source_select_alt;
      ctrl[bms_pkg::CTRL_ADC_BIT] = adc_enable;
   end

   // Set beats the write-one clear in the same cycle
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         done_flag <= 1'b0;
      else if (ce)
      begin
         if (cc_tick)
            done_flag <= 1'b1;
         else if (done_clr)
            done_flag <= 1'b0;
      end
   end
   assign host_alert = done_flag;

   // Reads: even address is high byte and snapshots the low byte
   wire in_cell = |cell_hit;
   wire in_temp = |temp_hit;
   wire is_sum = off[7:1] == bms_pkg::ADDR_SUM[7:1];
   wire is_cc = off[7:1] == bms_pkg::ADDR_CC[7:1];

   // One-hot hits per entry avoid index arithmetic on the address
   always_comb
   begin
      cell_word = 16'h0000;
      for (int i = 0; i < bms_pkg::NUM_CELLS; i++)
         if (cell_hit[i])
            cell_word = 16'(cell_reg[i]);
   end

   always_comb
   begin
      temp_word = 16'h0000;
      for (int i = 0; i < bms_pkg::NUM_TEMPS; i++)
         if (temp_hit[i])
            temp_word = 16'(temp_reg[i]);
   end

   wire [15:0] word =
      in_cell ? cell_word :
      in_temp ? temp_word :
      is_sum ? stack_sum_value :
      is_cc ? cc_result : 16'h0000;
   wire paired = in_cell || in_temp || is_sum || is_cc;

   always_comb
   begin
      next_rdata = 8'h00;
      if (off == bms_pkg::ADDR_STATUS)
         next_rdata = {done_flag, 7'h00};
      else if (off == bms_pkg::ADDR_CTRL)
         next_rdata = ctrl;
      else if (paired)
         next_rdata = off[0] ? low_shadow : word[15:8];
   end

   wire rd_take = ce && bus.rd;
   wire snap_take = rd_take && paired && !off[0];

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         rdata <= 8'h00;
      else if (rd_take)
         rdata <= next_rdata;
   end

   // Low byte frozen at the high-byte read, so a pair never tears
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         low_shadow <= 8'h00;
      else if (snap_take)
         low_shadow <= word[7:0];
   end
endmodule

// ### bms_pkg.sv
package bms_pkg;
   localparam int CLK_MHZ = 200;
   localparam int UPDATE_MS = 250;
   localparam int TEMP_MS = 2000;
   localparam int CYC_PER_MS = CLK_MHZ * 1000;
   localparam int UPDATE_CYCLES = UPDATE_MS * CYC_PER_MS;
   localparam int TEMP_CYCLES = TEMP_MS * CYC_PER_MS;
   localparam int NUM_CELLS = 15;
   localparam int NUM_TEMPS = 3;
   localparam int CELL_W = 14;
   localparam int SUM_W = 16;
   localparam int CC_W = 16;

   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_CTRL = 8'h01;
   localparam logic [7:0] ADDR_CELL_BASE = 8'h10;
   localparam logic [7:0] ADDR_TEMP_BASE = 8'h30;
   localparam logic [7:0] ADDR_SUM = 8'h38;
   localparam logic [7:0] ADDR_CC = 8'h3a;

   localparam int STAT_DONE_BIT = 7;
   localparam int CTRL_CONT_BIT = 0;
   localparam int CTRL_SHOT_BIT = 1;
   localparam int CTRL_TSEL_BIT = 2;
   localparam int CTRL_ADC_BIT = 3;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } bms_bus_t;
endpackage

// ### bms_timer.sv
`timescale 1ns/1ps
module bms_timer #(
   parameter int PERIOD = 1000
)
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic ce,
   input wire logic run,
   output logic tick
);
   logic [31:0] count;
   wire at_end = (count == 32'(PERIOD - 1));
   assign tick = run && at_end;
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         count <= 32'h0;
      else if (ce)
      begin
         if (!run || at_end)
            count <= 32'h0;
         else
            count <= count + 32'h1;
      end
   end
endmodule

// ### bms_meas_properties.sv
`timescale 1ns/1ps
module bms_meas_chk #(
   parameter int UPDATE_CYCLES = 20
)
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic ce,
   input wire logic enter_normal,
   input wire bms_pkg::bms_bus_t bus,
   input wire logic [7:0] rdata,
   input wire logic adc_enable,
   input wire logic host_alert
);
   localparam int UPD_MAX = UPDATE_CYCLES + 2;
   logic cont_q;
   wire wr_ctrl = ce && bus.wr && bus.addr == bms_pkg::ADDR_CTRL;
   wire wr_clr = ce && bus.wr && bus.addr == bms_pkg::ADDR_STATUS && bus.wdata[7];
   wire rd_on = ce && bus.rd;
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst) cont_q <= 1'b0;
      else if (wr_ctrl) cont_q <= bus.wdata[bms_pkg::CTRL_CONT_BIT];
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   a_rd_unmapped: assert property (rd_on && bus.addr == 8'h02 |=> rdata == 8'h00) else $error("unmapped read");
   a_rd_status: assert property (rd_on && bus.addr == bms_pkg::ADDR_STATUS |=> rdata[7] == $past(host_alert))
      else $error("status bit differs from alert");
   a_rd_adc: assert property (rd_on && bus.addr == bms_pkg::ADDR_CTRL |=> rdata[3] == $past(adc_enable))
      else $error("ctrl bit differs from adc enable");
   a_adc_normal: assert property (ce && enter_normal |=> adc_enable) else $error("adc enable not set");
   a_adc_hold: assert property ($fell(adc_enable) |-> $past(wr_ctrl && !bus.wdata[3])) else $error("adc enable lost");
   a_alert_fall: assert property ($fell(host_alert) |-> $past(wr_clr)) else $error("alert fell unasked");
   a_alert_cont: assert property (cont_q && $fell(host_alert) |-> ##[1:UPD_MAX] (host_alert || !cont_q))
      else $error("no result in continuous mode");
   a_rdata_hold: assert property (!rd_on |=> $stable(rdata)) else $error("read data moved");
   a_ce_freeze: assert property (!ce |=> $stable(host_alert) && $stable(adc_enable)) else $error("state moved");
endmodule

// ### bms_host.sv
`timescale 1ns/1ps
module bms_host
(
   input wire logic clk_sys,
   input wire logic [7:0] rdata,
   output bms_pkg::bms_bus_t bus
);
   initial bus = '0;
   // Also clears the done flag by writing its bit
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      bus.wr <= 1'b0;
   endtask
   // High byte first, low byte back to back
   task automatic rd16(input logic [7:0] a, output logic [15:0] v);
      @(posedge clk_sys);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      bus.addr <= a + 8'h01;
      #1 v[15:8] = rdata;
      @(posedge clk_sys);
      bus.rd <= 1'b0;
      #1 v[7:0] = rdata;
   endtask
endmodule

// ### bms_meas_tb.sv
`timescale 1ns/1ps
module bms_meas_tb;
   localparam int UPD = 20;
   localparam int TMP = 160;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic ce = 1'b0;
   logic enter_normal = 1'b0;
   logic sense_valid = 1'b0;
   logic signed [15:0] sense_sample = -16'sd3;
   logic [209:0] cell_code = '0;
   logic [41:0] therm_code = {14'h0333, 14'h0222, 14'h0111};
   logic [41:0] die_code = {14'h0c03, 14'h0c02, 14'h0c01};
   bms_pkg::bms_bus_t bus;
   logic [7:0] rdata;
   logic adc_enable;
   logic host_alert;
   logic [15:0] v;
   logic [15:0] s;
   int n_mismatch = 0;
   int checked = 0;
   int cyc = 0;
   bms_meas #(.UPDATE_CYCLES(UPD), .TEMP_CYCLES(TMP)) i_bms_meas (.clk_sys(clk_sys), .nrst(nrst), .ce(ce),
      .enter_normal(enter_normal), .cell_code(cell_code), .therm_code(therm_code), .die_code(die_code),
      .sense_sample(sense_sample), .sense_valid(sense_valid), .bus(bus), .rdata(rdata),
      .adc_enable(adc_enable), .host_alert(host_alert));
   bms_host i_bms_host (.clk_sys(clk_sys), .rdata(rdata), .bus(bus));
   initial forever #2.5 clk_sys = ~clk_sys;
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic stop_test;
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic wait_alert;
      for (int i = 0; i < 3 * UPD && host_alert !== 1'b1; i++) @(posedge clk_sys);
   endtask
   // Ceiling well above the whole sequence
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_mismatch++;
         stop_test();
      end
   end
   initial
   begin
      for (int i = 0; i < 15; i++) cell_code[14*i+:14] = 14'h1000 + i;
      repeat (3) @(posedge clk_sys);
      nrst <= 1'b1;
      ce <= 1'b1;
      i_bms_host.rd16(bms_pkg::ADDR_STATUS, v);
      chk("status ctrl", v, {8'h00, bms_pkg::CTRL_RESET});
      chk("adc_enable", {15'h0, adc_enable}, 16'h0000);
      enter_normal <= 1'b1;
      @(posedge clk_sys);
      enter_normal <= 1'b0;
      for (int k = 0; k < 2; k++)
      begin
         repeat (2 * UPD) @(posedge clk_sys);
         chk("adc_enable", {15'h0, adc_enable}, 16'h0001);
         s = 16'h0000;
         for (int i = 0; i < 15; i++) s = s + {2'b00, cell_code[14*i+:14]};
         i_bms_host.rd16(bms_pkg::ADDR_CELL_BASE, v);
         chk("cell0", v, {2'b00, cell_code[13:0]});
         i_bms_host.rd16(bms_pkg::ADDR_CELL_BASE + 8'h1c, v);
         chk("cell14", v, {2'b00, cell_code[209:196]});
         i_bms_host.rd16(bms_pkg::ADDR_SUM, v);
         chk("stack sum", v, s >> 2);
         cell_code[13:0] <= 14'h0400;
      end
      $display("cells done");
      for (int k = 1; k >= 0; k--)
      begin
         i_bms_host.wr(bms_pkg::ADDR_CTRL, k ? 8'h0c : 8'h08);
         repeat (2 * TMP) @(posedge clk_sys);
         for (int j = 0; j < 3; j++)
         begin
            i_bms_host.rd16(bms_pkg::ADDR_TEMP_BASE + 8'(2 * j), v);
            chk("temp", v, {2'b00, k ? therm_code[14*j+:14] : die_code[14*j+:14]});
         end
      end
      $display("temps done");
      sense_valid <= 1'b1;
      i_bms_host.wr(bms_pkg::ADDR_CTRL, 8'h0a);
      wait_alert();
      chk("alert", {15'h0, host_alert}, 16'h0001);
      i_bms_host.rd16(bms_pkg::ADDR_CC, v);
      chk("charge", v, 16'hffc4);
      i_bms_host.rd16(bms_pkg::ADDR_STATUS, v);
      chk("trigger", {15'h0, v[1]}, 16'h0000);
      ce <= 1'b0;
      i_bms_host.wr(bms_pkg::ADDR_STATUS, 8'h80);
      ce <= 1'b1;
      chk("frozen alert", {15'h0, host_alert}, 16'h0001);
      i_bms_host.wr(bms_pkg::ADDR_STATUS, 8'h80);
      repeat (3 * UPD) @(posedge clk_sys);
      chk("one shot", {15'h0, host_alert}, 16'h0000);
      $display("single done");
      i_bms_host.wr(bms_pkg::ADDR_CTRL, 8'h09);
      for (int k = 0; k < 2; k++)
      begin
         wait_alert();
         chk("cont alert", {15'h0, host_alert}, 16'h0001);
         i_bms_host.rd16(bms_pkg::ADDR_CC, v);
         chk("cont charge", v, 16'hffc4);
         i_bms_host.wr(bms_pkg::ADDR_STATUS, 8'h80);
      end
      i_bms_host.wr(bms_pkg::ADDR_CTRL, 8'h08);
      repeat (UPD + 2) @(posedge clk_sys);
      i_bms_host.wr(bms_pkg::ADDR_STATUS, 8'h80);
      repeat (3 * UPD) @(posedge clk_sys);
      chk("stopped", {15'h0, host_alert}, 16'h0000);
      i_bms_host.rd16(8'h02, v);
      chk("unmapped", v, 16'h0000);
      $display("continuous done");
      stop_test();
   end
endmodule
bind bms_meas bms_meas_chk #(.UPDATE_CYCLES(UPDATE_CYCLES)) i_bms_meas_chk (.clk_sys, .nrst, .ce, .enter_normal,
   .bus, .rdata, .adc_enable, .host_alert);
